/* hw/rpsb_pkg.sv */
// shared constants, types and decode helpers for the bus b / bus c rgb palette select block
// assumes one 20 MHz clock and a byte-wide register port driven by the serial host engine
package rpsb_pkg;
	// register addresses of the four select registers
	localparam logic [7:0] ADDR_B12 = 8'h0B;
	localparam logic [7:0] ADDR_B34 = 8'h0C;
	localparam logic [7:0] ADDR_C12 = 8'h0D;
	localparam logic [7:0] ADDR_C34 = 8'h0E;
	localparam int NUM_REGS = 4;
	// field positions inside one select register
	localparam int EN_HI_BIT = 7;
	localparam int SEL_HI_MSB = 6;
	localparam int SEL_HI_LSB = 4;
	localparam int EN_LO_BIT = 3;
	localparam int SEL_LO_MSB = 2;
	localparam int SEL_LO_LSB = 0;
	// palette bit for each colour
	localparam int SEL_RED_BIT = 2;
	localparam int SEL_GRN_BIT = 1;
	localparam int SEL_BLU_BIT = 0;
	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [7:0] LEVEL_ZERO = 8'h00;
	// highest current code, 125 uA per step
	localparam logic [7:0] LEVEL_MAX = 8'hC0;
	// cathode line offset from the row's own anode line, per colour
	localparam logic [1:0] RED_LINE_OFS = 2'h2;
	localparam logic [1:0] GRN_LINE_OFS = 2'h1;
	localparam logic [1:0] BLU_LINE_OFS = 2'h3;
	// colour slots
	localparam int COL_RED = 0;
	localparam int COL_GRN = 1;
	localparam int COL_BLU = 2;
	// fade step timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int FADE_STEP_NS = 1000;
	localparam int FADE_DIV_CYCLES = (FADE_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 : (FADE_STEP_NS / CLK_PERIOD_NS);
	localparam int FADE_DIV_W = 5;
	localparam logic [FADE_DIV_W-1:0] FADE_DIV_LAST = FADE_DIV_W'(FADE_DIV_CYCLES - 1);
	localparam logic [FADE_DIV_W-1:0] FADE_DIV_ZERO = 5'h00;

	typedef logic [7:0] rpsb_level_t;
	typedef logic [2:0] rpsb_palette_t;
	typedef enum logic [1:0] {FADE_HOLD, FADE_UP, FADE_DOWN} rpsb_fade_e;

	// address falls on one of the four select registers
	function automatic logic rpsb_reg_hit(input logic [7:0] addr);
		return (addr >= ADDR_B12) && (addr <= ADDR_C34);
	endfunction

	// index of the select register at an address
	function automatic logic [1:0] rpsb_reg_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - ADDR_B12;
		return diff[1:0];
	endfunction

	// cathode line carrying a colour for a given anode row
	function automatic logic [1:0] rpsb_cathode_line(input logic [1:0] row, input int colour);
		logic [1:0] ofs;
		ofs = (colour == COL_RED) ? RED_LINE_OFS : ((colour == COL_GRN) ? GRN_LINE_OFS : BLU_LINE_OFS);
		return row + ofs;
	endfunction

	// saturate a level code at the top setting
	function automatic rpsb_level_t rpsb_clamp(input rpsb_level_t lvl);
		return (lvl > LEVEL_MAX) ? LEVEL_MAX : lvl;
	endfunction
endpackage

/* hw/rpsb_row_route.sv */
// target picker for one rgb module: enable and palette select the three colour targets
// assumes clamped level inputs and a synchronous active-low reset
`timescale 1ns/1ns
module rpsb_row_route (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// module settings
	input wire logic i_enable,
	input wire rpsb_pkg::rpsb_palette_t i_palette,
	// stored levels, clamped
	input wire rpsb_pkg::rpsb_level_t i_red_lvl0,
	input wire rpsb_pkg::rpsb_level_t i_red_lvl1,
	input wire rpsb_pkg::rpsb_level_t i_grn_lvl0,
	input wire rpsb_pkg::rpsb_level_t i_grn_lvl1,
	input wire rpsb_pkg::rpsb_level_t i_blu_lvl0,
	input wire rpsb_pkg::rpsb_level_t i_blu_lvl1,
	// chosen targets
	output logic [2:0][7:0] o_target
);
	import rpsb_pkg::*;

	logic [2:0][7:0] target_ff; // registered targets
	logic [2:0][7:0] nxt_target; // next targets

	// pick level 0 or 1 per colour, or zero while disabled
	always_comb begin
		nxt_target = '0;
		if (i_enable) begin
			nxt_target[COL_RED] = i_palette[SEL_RED_BIT] ? i_red_lvl1 : i_red_lvl0;
			nxt_target[COL_GRN] = i_palette[SEL_GRN_BIT] ? i_grn_lvl1 : i_grn_lvl0;
			nxt_target[COL_BLU] = i_palette[SEL_BLU_BIT] ? i_blu_lvl1 : i_blu_lvl0;
		end
	end

	// register targets
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			target_ff <= '0;
		end else begin
			target_ff <= nxt_target;
		end
	end

	assign o_target = target_ff;

	AST_TARGET_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!i_enable |=> (o_target == '0))
		else $error("disabled module has a nonzero target");

	AST_TARGET_ON: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_enable |=> (o_target[COL_RED] == ($past(i_palette[SEL_RED_BIT]) ? $past(i_red_lvl1) : $past(i_red_lvl0)))
			&& (o_target[COL_GRN] == ($past(i_palette[SEL_GRN_BIT]) ? $past(i_grn_lvl1) : $past(i_grn_lvl0)))
			&& (o_target[COL_BLU] == ($past(i_palette[SEL_BLU_BIT]) ? $past(i_blu_lvl1) : $past(i_blu_lvl0))))
		else $error("enabled module target does not follow its palette");
endmodule

/* hw/rpsb_fade.sv */
// fade engine for one led: moves the current code one step toward its target per fade tick
// assumes a one-cycle step pulse from the shared divider
`timescale 1ns/1ns
module rpsb_fade (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// step pulse and goal
	input wire logic i_step,
	input wire rpsb_pkg::rpsb_level_t i_target,
	// present current code
	output rpsb_pkg::rpsb_level_t o_level
);
	import rpsb_pkg::*;

	rpsb_level_t level_ff; // current code
	rpsb_level_t nxt_level; // next code
	rpsb_fade_e dir; // direction of this step

	// step toward target, never jump
	always_comb begin
		nxt_level = level_ff;
		if (level_ff < i_target) begin
			dir = FADE_UP;
		end else if (level_ff > i_target) begin
			dir = FADE_DOWN;
		end else begin
			dir = FADE_HOLD;
		end
		if (i_step) begin
			case (dir)
				FADE_UP: nxt_level = level_ff + 8'h01;
				FADE_DOWN: nxt_level = level_ff - 8'h01;
				FADE_HOLD: nxt_level = level_ff;
				default: nxt_level = level_ff;
			endcase
		end
	end

	// register code
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			level_ff <= LEVEL_ZERO;
		end else begin
			level_ff <= nxt_level;
		end
	end

	assign o_level = level_ff;

	AST_FADE_DOWN_STEP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_step && (o_level > i_target)) |=> (o_level == $past(o_level) - 8'h01))
		else $error("fade down did not take exactly one step");

	AST_FADE_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!i_step |=> $stable(o_level))
		else $error("fade level moved without a step");
endmodule

/* hw/rpsb_top.sv */
// select registers for the bus b and bus c rgb modules, with per-led fading
// assumes the serial host engine presents a byte register port synchronous to i_ref_clk
`timescale 1ns/1ns
module rpsb_top (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr_en,
	input wire logic i_reg_rd_en,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// stored current levels
	input wire rpsb_pkg::rpsb_level_t i_red_level_0,
	input wire rpsb_pkg::rpsb_level_t i_red_level_1,
	input wire rpsb_pkg::rpsb_level_t i_green_level_0,
	input wire rpsb_pkg::rpsb_level_t i_green_level_1,
	input wire rpsb_pkg::rpsb_level_t i_blue_level_0,
	input wire rpsb_pkg::rpsb_level_t i_blue_level_1,
	// line currents, [row][line] per bus
	output logic [3:0][3:0][7:0] o_bus_b_current,
	output logic [3:0][3:0][7:0] o_bus_c_current
);
	import rpsb_pkg::*;

	localparam int TICK_GAP = FADE_DIV_CYCLES; // cycles between fade steps
	localparam int TICK_WAIT = TICK_GAP - 1; // quiet cycles between two ticks

	// register file state
	logic [NUM_REGS-1:0][7:0] sel_ff; // four select registers
	logic [NUM_REGS-1:0][7:0] nxt_sel;
	logic [7:0] rdata_ff; // read data
	logic [7:0] nxt_rdata;
	logic addr_hit; // address on the map
	logic [1:0] addr_idx; // register index

	// fade divider state
	logic [FADE_DIV_W-1:0] div_ff; // divider count
	logic [FADE_DIV_W-1:0] nxt_div;
	logic step_ff; // one-cycle fade tick
	logic nxt_step;

	// level saturation state
	logic [5:0][7:0] lvl_ff; // red0 red1 grn0 grn1 blu0 blu1
	logic [5:0][7:0] nxt_lvl;

	// per-row signals
	logic [7:0] row_en; // enable per row, b rows then c rows
	logic [7:0][2:0] row_pal; // palette per row
	logic [7:0][2:0][7:0] row_tgt; // fade targets
	logic [7:0][2:0][7:0] fade_lvl; // fade outputs

	// output state
	logic [7:0][3:0][7:0] cur_ff; // registered line currents
	logic [7:0][3:0][7:0] nxt_cur;

	// address decode shared by read and write
	always_comb begin
		addr_hit = rpsb_reg_hit(i_reg_addr);
		addr_idx = rpsb_reg_index(i_reg_addr);
	end

	// register writes and reads
	always_comb begin
		nxt_sel = sel_ff;
		nxt_rdata = rdata_ff;
		if (i_reg_wr_en && addr_hit) begin
			nxt_sel[addr_idx] = i_reg_wdata;
		end
		if (i_reg_rd_en) begin
			if (addr_hit) begin
				nxt_rdata = sel_ff[addr_idx];
			end else begin
				nxt_rdata = RDATA_RESET; // unmapped reads zero
			end
		end
	end

	// register file flops
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			sel_ff <= {NUM_REGS{REG_RESET}};
			rdata_ff <= RDATA_RESET;
		end else begin
			sel_ff <= nxt_sel;
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_reg_rdata = rdata_ff;

	// fade tick divider
	always_comb begin
		nxt_div = div_ff + 5'h01;
		nxt_step = 1'b0;
		if (div_ff == FADE_DIV_LAST) begin
			nxt_div = FADE_DIV_ZERO;
			nxt_step = 1'b1;
		end
	end

	// divider flops
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			div_ff <= FADE_DIV_ZERO;
			step_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			step_ff <= nxt_step;
		end
	end

	// saturate the stored levels
	always_comb begin
		nxt_lvl[0] = rpsb_clamp(i_red_level_0);
		nxt_lvl[1] = rpsb_clamp(i_red_level_1);
		nxt_lvl[2] = rpsb_clamp(i_green_level_0);
		nxt_lvl[3] = rpsb_clamp(i_green_level_1);
		nxt_lvl[4] = rpsb_clamp(i_blue_level_0);
		nxt_lvl[5] = rpsb_clamp(i_blue_level_1);
	end

	// level flops
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			lvl_ff <= '0;
		end else begin
			lvl_ff <= nxt_lvl;
		end
	end

	// one route and three fade engines per row
	genvar g;
	genvar c;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_row
			localparam int REG_IDX = g / 2; // owning register
			localparam bit HI_HALF = ((g % 2) == 0); // row sits in upper nibble

			// pull this row's fields out of its register
			if (HI_HALF) begin : g_hi
				assign row_en[g] = sel_ff[REG_IDX][EN_HI_BIT];
				assign row_pal[g] = sel_ff[REG_IDX][SEL_HI_MSB:SEL_HI_LSB];
			end else begin : g_lo
				assign row_en[g] = sel_ff[REG_IDX][EN_LO_BIT];
				assign row_pal[g] = sel_ff[REG_IDX][SEL_LO_MSB:SEL_LO_LSB];
			end

			// target selection
			rpsb_row_route u_route (
				.i_ref_clk(i_ref_clk),
				.i_rst_b(i_rst_b),
				.i_enable(row_en[g]),
				.i_palette(row_pal[g]),
				.i_red_lvl0(lvl_ff[0]),
				.i_red_lvl1(lvl_ff[1]),
				.i_grn_lvl0(lvl_ff[2]),
				.i_grn_lvl1(lvl_ff[3]),
				.i_blu_lvl0(lvl_ff[4]),
				.i_blu_lvl1(lvl_ff[5]),
				.o_target(row_tgt[g])
			);

			// per-colour fade engines
			for (c = 0; c < 3; c = c + 1) begin : g_col
				rpsb_fade u_fade (
					.i_ref_clk(i_ref_clk),
					.i_rst_b(i_rst_b),
					.i_step(step_ff),
					.i_target(row_tgt[g][c]),
					.o_level(fade_lvl[g][c])
				);
			end

			AST_ANODE_DARK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				cur_ff[g][g % 4] == LEVEL_ZERO)
				else $error("anode line of a row carries cathode current");

			AST_ROUTE_RED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				1'b1 |=> cur_ff[g][rpsb_cathode_line(2'(g % 4), COL_RED)] == $past(fade_lvl[g][COL_RED]))
				else $error("red current not on its cathode line");

			AST_ROUTE_GB: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				1'b1 |=> (cur_ff[g][rpsb_cathode_line(2'(g % 4), COL_GRN)] == $past(fade_lvl[g][COL_GRN]))
					&& (cur_ff[g][rpsb_cathode_line(2'(g % 4), COL_BLU)] == $past(fade_lvl[g][COL_BLU])))
				else $error("green or blue current not on its cathode line");

			AST_OFF_DRAINS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				(!row_en[g] && step_ff && (fade_lvl[g][COL_RED] > LEVEL_ZERO) && !$past(row_en[g]))
					|=> fade_lvl[g][COL_RED] < $past(fade_lvl[g][COL_RED]))
				else $error("disabled row failed to fade down");

			AST_OFF_DRAINS_GRN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				(!row_en[g] && step_ff && (fade_lvl[g][COL_GRN] > LEVEL_ZERO) && !$past(row_en[g]))
					|=> fade_lvl[g][COL_GRN] < $past(fade_lvl[g][COL_GRN]))
				else $error("disabled row failed to fade green down");

			AST_OFF_DRAINS_BLU: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				(!row_en[g] && step_ff && (fade_lvl[g][COL_BLU] > LEVEL_ZERO) && !$past(row_en[g]))
					|=> fade_lvl[g][COL_BLU] < $past(fade_lvl[g][COL_BLU]))
				else $error("disabled row failed to fade blue down");

			// a tick reaches the lines two edges later, so quiet cycles keep them still
			AST_CUR_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
				!step_ff |-> ##2 $stable(cur_ff[g]))
				else $error("row current moved without a fade tick");
		end
	endgenerate

	// steer each colour onto its cathode line, anode line dark
	always_comb begin
		nxt_cur = '0;
		for (int r = 0; r < 8; r++) begin
			for (int k = 0; k < 3; k++) begin
				nxt_cur[r][rpsb_cathode_line(2'(r % 4), k)] = fade_lvl[r][k];
			end
		end
	end

	// output flops, same map on both buses
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign o_bus_b_current = cur_ff[3:0];
	assign o_bus_c_current = cur_ff[7:4];

	// write, one quiet cycle, then a read of the same register
	sequence s_write;
		i_reg_wr_en && addr_hit;
	endsequence

	// no other write may slip in before the read
	sequence s_gap;
		!i_reg_wr_en;
	endsequence

	sequence s_read_same;
		i_reg_rd_en && !i_reg_wr_en && (i_reg_addr == $past(i_reg_addr, 2));
	endsequence

	AST_WRITE_READBACK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		s_write ##1 s_gap ##1 s_read_same |=> (o_reg_rdata == $past(i_reg_wdata, 3)))
		else $error("select register did not read back as written");

	AST_RESET_CLEAR: assert property (@(posedge i_ref_clk)
		!i_rst_b |=> ((sel_ff == '0) && (o_reg_rdata == RDATA_RESET) && (row_en == 8'h00)))
		else $error("select fields not cleared by reset");

	AST_UNMAPPED_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_reg_rd_en && !addr_hit) |=> (o_reg_rdata == RDATA_RESET))
		else $error("unmapped read returned nonzero");

	AST_LEVEL_CLAMP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_red_level_1 > LEVEL_MAX) |=> (lvl_ff[1] == LEVEL_MAX))
		else $error("oversized level not saturated");

	AST_TICK_PERIOD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		step_ff |=> !step_ff ##TICK_WAIT step_ff)
		else $error("fade tick spacing wrong");

	// register port checks
	AST_WRITE_LANDS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_reg_wr_en && addr_hit) |=> (sel_ff[$past(addr_idx)] == $past(i_reg_wdata)))
		else $error("mapped write did not land in its register");

	AST_WRITE_REFUSED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_reg_wr_en && !addr_hit) |=> $stable(sel_ff))
		else $error("unmapped write changed a select register");

	AST_SEL_STABLE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!i_reg_wr_en |=> $stable(sel_ff))
		else $error("select register changed without a write");

	AST_READ_DATA: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(i_reg_rd_en && addr_hit) |=> (o_reg_rdata == $past(sel_ff[addr_idx])))
		else $error("read data differs from the addressed register");

	AST_RDATA_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!i_reg_rd_en |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");

	// level and output checks
	AST_LEVEL_PASS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		((i_red_level_0 <= LEVEL_MAX) && (i_green_level_0 <= LEVEL_MAX) && (i_blue_level_0 <= LEVEL_MAX))
			|=> (lvl_ff[0] == $past(i_red_level_0))
			&& (lvl_ff[2] == $past(i_green_level_0))
			&& (lvl_ff[4] == $past(i_blue_level_0)))
		else $error("in-range level altered by saturation");

	AST_CUR_RESET: assert property (@(posedge i_ref_clk)
		!i_rst_b |=> ((cur_ff == '0) && !step_ff))
		else $error("line currents not cleared by reset");
endmodule

/* tb/rpsb_host.sv */
// host model: plays the serial host engine on the byte register port
// assumes one clock; requests launched just after a rising edge, held one cycle
`timescale 1ns/1ns
module rpsb_host (
	// clock
	input wire logic i_ref_clk,
	// register port toward the block
	output logic [7:0] o_addr,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata
);
	// idle values at time zero
	initial begin
		o_addr = 8'h00;
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_wdata = 8'h00;
	end
	// one write; address and data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr_en <= 1'b1;
		@(posedge i_ref_clk);
		o_wr_en <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// one read; data taken once it has settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_rd_en <= 1'b1;
		@(posedge i_ref_clk);
		o_rd_en <= 1'b0;
		o_addr <= ~a;
		@(posedge i_ref_clk);
		#1;
		d = i_rdata;
	endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the bus b / bus c palette select block
// assumes the host model in rpsb_host and a 20 MHz clock
`timescale 1ns/1ns
module tb;
	import rpsb_pkg::*;
	logic i_ref_clk;
	logic i_rst_b;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr_en, reg_rd_en;
	rpsb_level_t lvl [6]; // red0 red1 grn0 grn1 blu0 blu1
	logic [3:0][3:0][7:0] cur_b, cur_c;
	logic [2:0] pal [2][4]; // [bus][row] palette now programmed
	logic on [2][4]; // [bus][row] enable now programmed
	logic [7:0] s;
	int errors, n_tests;

	rpsb_host u_host (.i_ref_clk(i_ref_clk), .o_addr(reg_addr), .o_wr_en(reg_wr_en),
		.o_rd_en(reg_rd_en), .o_wdata(reg_wdata), .i_rdata(reg_rdata));

	rpsb_top u_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(reg_addr),
		.i_reg_wr_en(reg_wr_en), .i_reg_rd_en(reg_rd_en), .i_reg_wdata(reg_wdata),
		.o_reg_rdata(reg_rdata), .i_red_level_0(lvl[0]), .i_red_level_1(lvl[1]),
		.i_green_level_0(lvl[2]), .i_green_level_1(lvl[3]), .i_blue_level_0(lvl[4]),
		.i_blue_level_1(lvl[5]), .o_bus_b_current(cur_b), .o_bus_c_current(cur_c));

	// clock source
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	// compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// let n edges pass, then settle
	task automatic idle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	// every line of every row against the programmed settings
	task automatic check_rows();
		logic [7:0] e;
		for (int b = 0; b < 2; b++) for (int r = 0; r < 4; r++) for (int l = 0; l < 4; l++) begin
			e = 8'h00;
			if (on[b][r] && l == (r + 2) % 4) e = lvl[0 + pal[b][r][2]];
			if (on[b][r] && l == (r + 1) % 4) e = lvl[2 + pal[b][r][1]];
			if (on[b][r] && l == (r + 3) % 4) e = lvl[4 + pal[b][r][0]];
			check(b ? cur_c[r][l] : cur_b[r][l], e);
		end
	endtask

	// write all four select bytes from pal and on, reading each back
	task automatic program_all();
		logic [7:0] d;
		for (int b = 0; b < 2; b++) for (int k = 0; k < 2; k++) begin
			d = {on[b][2*k], pal[b][2*k], on[b][2*k+1], pal[b][2*k+1]};
			u_host.wr(ADDR_B12 + 8'(2 * b + k), d);
			u_host.rd(ADDR_B12 + 8'(2 * b + k), s);
			check(s, d);
		end
	endtask

	// reset state and unmapped places
	task automatic t_reset();
		for (int r = 0; r < 4; r++) begin
			on[0][r] = 1'b0;
			on[1][r] = 1'b0;
			pal[0][r] = 3'h0;
			pal[1][r] = 3'h0;
		end
		idle(1);
		check_rows();
		for (int i = 0; i < 6; i++) begin
			u_host.rd(8'h0A + 8'(i), s);
			check(s, 8'h00);
		end
		u_host.wr(8'h0F, 8'hFF);
		u_host.rd(8'h0F, s);
		check(s, 8'h00);
		u_host.rd(ADDR_C34, s);
		check(s, 8'h00);
		$display("test reset done");
	endtask

	// palette code r + sh on bus b row r and r + 4 - sh on bus c row r, all rows enabled
	task automatic t_map(input int sh);
		for (int r = 0; r < 4; r++) begin
			pal[0][r] = 3'(r + sh);
			pal[1][r] = 3'(r + 4 - sh);
			on[0][r] = 1'b1;
			on[1][r] = 1'b1;
		end
		program_all();
		idle(200);
		check_rows();
		$display("test map %0d done", sh);
	endtask

	// disabling ramps down instead of cutting off
	task automatic t_fade_off();
		for (int i = 0; i < 4; i++) begin
			u_host.wr(ADDR_B12 + 8'(i), 8'h00);
			on[i / 2][2 * (i % 2)] = 1'b0;
			on[i / 2][2 * (i % 2) + 1] = 1'b0;
		end
		idle(25);
		s = cur_b[0][2];
		check({7'h00, s > 8'h02 && s < 8'h05}, 8'h01);
		idle(200);
		check_rows();
		$display("test fade off done");
	endtask

	// oversized level saturates, then a second reset clears everything
	task automatic t_clamp();
		@(posedge i_ref_clk);
		lvl[1] <= 8'hFF;
		u_host.wr(ADDR_B12, 8'hC0);
		idle(4000);
		check(cur_b[0][2], 8'hC0);
		@(posedge i_ref_clk);
		i_rst_b <= 1'b0;
		idle(4);
		check(cur_b[0][2], 8'h00);
		@(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		u_host.rd(ADDR_B12, s);
		check(s, 8'h00);
		$display("test clamp done");
	endtask

	// counts and verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		errors = 0;
		n_tests = 0;
		i_rst_b = 1'b0;
		lvl[0] = 8'h03;
		lvl[1] = 8'h05;
		lvl[2] = 8'h02;
		lvl[3] = 8'h06;
		lvl[4] = 8'h04;
		lvl[5] = 8'h07;
		repeat (4) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		t_reset();
		t_map(0);
		t_map(4);
		t_fade_off();
		t_clamp();
		conclude();
	end

	// hang guard, about four times the expected run
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		errors++;
		conclude();
	end
endmodule
